// ==== hw/frp_flash_range_protection.sv ====
// Summary of operation
// [R1] Upper-window disable 0 enables the upper window, 1 removes it.
// [R2] Upper size field is writable only while upper disable is set.
// [R3] Lower-window disable 0 enables the lower window, 1 removes it.
// [R4] Lower size field is writable only while lower disable is set.
// [R5] Polarity 1: enabled windows protected; both disabled protects nothing.
// [R6] Polarity 0 with both windows disabled protects the whole array.
// [R7] Polarity 0: enabled windows open, everything else protected.
// [R8] Upper size 0..3 starts at f800, f000, e000, c000, ends at ffff.
// [R9] Lower size 0..3 starts at 4000, ends at 43ff, 47ff, 4fff, 5fff.
// [R10] Software may change the setting once it has been loaded.
// [R11] A write asking for a forbidden scenario leaves the register alone.
// [R12] Reading the register returns the scenario in force.
// [R13] Only transitions of the allowed-scenario table are taken.
// [R14] Software keeps the spare bit six erased.
// [R15] Polarity may go from 1 to 0 only, never back.
// [R16] After reset the setting is loaded from flash byte ff0d.
// [R17] Protected program/erase or guarded mass erase sets the violation flag.
// [R18] Scenario number is polarity, upper disable, lower disable.
// [R19] Once loaded, the protection decision follows the current register contents.
`timescale 1ns/1ps
`default_nettype none
module frp_flash_range_protection (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic             flash_rd_req_o,
    output logic      [15:0] flash_rd_addr_o,
    input  wire logic        flash_rd_valid_i,
    input  wire logic [7:0]  flash_rd_data_i,
    input  wire logic        cmd_valid_i,
    input  wire logic        cmd_pgm_ers_i,
    input  wire logic        cmd_mass_i,
    input  wire logic [15:0] cmd_addr_i,
    output logic             prot_hit_o,
    output logic             irq_o
);
    // ==================================================================
    // State
    typedef struct packed {
        frp_pkg::frp_state_type st;
        logic [7:0]             cfg;
        logic                   viol;
        logic                   mask;
        logic                   pready;
        logic                   pslverr;
        logic [31:0]            prdata;
        logic                   irq;
        logic                   rd_req;
        logic                   hit;
    } frp_regs_type;

    frp_regs_type r_r;
    frp_regs_type r_nxt;

    // ==================================================================
    // Decoding helpers
    function automatic logic [2:0] scen(input logic [7:0] c);
        scen = {c[frp_pkg::POL_BIT], c[frp_pkg::UDIS_BIT],
                c[frp_pkg::LDIS_BIT]}; // R18
    endfunction : scen

    function automatic logic in_windows(input logic [7:0]  c,
                                        input logic [15:0] a);
        logic [15:0] hs;
        logic [15:0] le;
        hs = frp_pkg::HI_START[16*c[4:3] +: 16]; // R8
        le = frp_pkg::LO_END[16*c[1:0] +: 16]; // R9
        in_windows = (!c[frp_pkg::UDIS_BIT] && a >= hs) || // R1
                     (!c[frp_pkg::LDIS_BIT] && a >= frp_pkg::LO_BASE &&
                      a <= le); // R3
    endfunction : in_windows

    function automatic logic is_prot(input logic [7:0]  c,
                                     input logic [15:0] a);
        // R5 R6 R7 R19
        is_prot = c[frp_pkg::POL_BIT] ? in_windows(c, a)
                                      : !in_windows(c, a);
    endfunction : is_prot

    function automatic logic any_prot(input logic [7:0] c);
        any_prot = (scen(c) != 3'h7);
    endfunction : any_prot

    // {mapped, index}
    function automatic logic [2:0] map(input logic [7:0] a);
        case (a)
            frp_pkg::CFG_OFS:   map = 3'h4;
            frp_pkg::STAT_OFS:  map = 3'h5;
            frp_pkg::MASK_OFS:  map = 3'h6;
            frp_pkg::STATE_OFS: map = 3'h7;
            default:            map = 3'h0;
        endcase
    endfunction : map

    // ==================================================================
    // Combinational next state
    logic       setup;
    logic       wr;
    logic [2:0] wmap;
    logic [2:0] rmap;
    logic       viol_ev;
    logic [7:0] cand;
    logic       loaded;

    assign setup   = psel_i && !penable_i;
    assign wr      = psel_i && penable_i && r_r.pready && pwrite_i;
    assign wmap    = map(paddr_i);
    assign rmap    = map(paddr_i);
    assign loaded  = (r_r.st == frp_pkg::FRP_RUN);
    // Until the byte is loaded, treat every address as protected
    assign viol_ev = cmd_valid_i &&
                     ((cmd_pgm_ers_i &&
                       (!loaded || is_prot(r_r.cfg, cmd_addr_i))) ||
                      (cmd_mass_i && (!loaded || any_prot(r_r.cfg))));

    always_comb begin
        r_nxt = r_r;
        cand  = pwdata_i[7:0];
        // The spare bit is nonvolatile and never changed by a bus write
        cand[frp_pkg::SPARE_BIT] = r_r.cfg[frp_pkg::SPARE_BIT];
        if (!r_r.cfg[frp_pkg::UDIS_BIT]) begin
            cand[4:3] = r_r.cfg[4:3]; // R2
        end
        if (!r_r.cfg[frp_pkg::LDIS_BIT]) begin
            cand[1:0] = r_r.cfg[1:0]; // R4
        end
        if (ce_i) begin
            // Zero-wait slave with one registered stage: pready in access
            r_nxt.pready  = setup;
            r_nxt.pslverr = setup && !rmap[2];
            r_nxt.hit     = !loaded || is_prot(r_r.cfg, cmd_addr_i); // R19
            if (setup) begin
                case (rmap)
                    3'h4:    r_nxt.prdata = {24'h0, r_r.cfg}; // R12
                    3'h5:    r_nxt.prdata = {31'h0, r_r.viol};
                    3'h6:    r_nxt.prdata = {31'h0, r_r.mask};
                    3'h7:    r_nxt.prdata = {28'h0, loaded, scen(r_r.cfg)};
                    default: r_nxt.prdata = 32'h0;
                endcase
            end
            if (wr && wmap == 3'h6) begin
                r_nxt.mask = pwdata_i[0];
            end
            // Set wins over the write-one clear
            r_nxt.viol = (r_r.viol && !(wr && wmap == 3'h5 && pwdata_i[0]))
                         || viol_ev; // R17
            case (r_r.st)
                frp_pkg::FRP_LOAD: begin
                    if (flash_rd_valid_i) begin
                        r_nxt.cfg    = flash_rd_data_i; // R16
                        r_nxt.st     = frp_pkg::FRP_RUN;
                        r_nxt.rd_req = 1'b0;
                    end
                end
                frp_pkg::FRP_RUN: begin
                    // Polarity 0->1 is absent from the table, so refused
                    if (wr && wmap == 3'h4 &&
                        frp_pkg::ALLOWED[{scen(r_r.cfg), scen(cand)}]) begin
                        r_nxt.cfg = cand; // R10 R11 R13 R15
                    end
                end
                default: r_nxt.st = frp_pkg::FRP_LOAD;
            endcase
            r_nxt.irq = r_nxt.viol && r_nxt.mask;
        end
    end

    // ==================================================================
    // Registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_r.st      <= frp_pkg::FRP_LOAD;
            r_r.cfg     <= frp_pkg::CFG_RST;
            r_r.viol    <= 1'b0;
            r_r.mask    <= frp_pkg::MASK_RST;
            r_r.pready  <= 1'b0;
            r_r.pslverr <= 1'b0;
            r_r.prdata  <= 32'h0;
            r_r.irq     <= 1'b0;
            r_r.rd_req  <= 1'b1;
            r_r.hit     <= 1'b1;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign prdata_o        = r_r.prdata;
    assign pready_o        = r_r.pready;
    assign pslverr_o       = r_r.pslverr;
    assign flash_rd_req_o  = r_r.rd_req;
    assign flash_rd_addr_o = frp_pkg::PROT_BYTE_ADDR; // R16
    assign prot_hit_o      = r_r.hit;
    assign irq_o           = r_r.irq;

    // ==================================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic [2:0] scen_now;
    assign scen_now = scen(r_r.cfg);

    chk_pol_no_rise: assert property ( // R15
        loaded && !r_r.cfg[frp_pkg::POL_BIT]
        |=> !r_r.cfg[frp_pkg::POL_BIT])
        else $error("polarity rose from 0 to 1");

    chk_usize_lock: assert property ( // R2
        loaded && !r_r.cfg[frp_pkg::UDIS_BIT] |=> $stable(r_r.cfg[4:3]))
        else $error("upper size changed while window enabled");

    chk_lsize_lock: assert property ( // R4
        loaded && !r_r.cfg[frp_pkg::LDIS_BIT] |=> $stable(r_r.cfg[1:0]))
        else $error("lower size changed while window enabled");

    chk_scen_table: assert property ( // R13
        loaded |=> frp_pkg::ALLOWED[{$past(scen_now), scen_now}])
        else $error("forbidden scenario transition taken");

    chk_load_byte: assert property ( // R16
        !loaded && ce_i && flash_rd_valid_i
        |=> loaded && r_r.cfg == $past(flash_rd_data_i))
        else $error("protection byte not loaded");

    chk_viol_set: assert property ( // R17
        ce_i && viol_ev |=> r_r.viol ##1 (r_r.viol || $past(wr)))
        else $error("violation flag not set");

    chk_full_prot: assert property ( // R6
        ce_i && loaded && scen_now == 3'h3 |=> prot_hit_o)
        else $error("full protection not applied");

    chk_no_prot: assert property ( // R5
        ce_i && loaded && scen_now == 3'h7 |=> !prot_hit_o)
        else $error("protection applied with none selected");

    chk_apb_answer: assert property (
        ce_i && setup |=> pready_o ##1 (!pready_o || !$past(ce_i)))
        else $error("apb answer not one cycle after setup");

    chk_irq_level: assert property (
        irq_o == (r_r.viol && r_r.mask) || !$past(ce_i))
        else $error("interrupt level disagrees with status");

    // ==================================================================
    // Window decode checks, known addresses in scenarios 0, 1, 4 and 6
    chk_hi_size_hit: assert property ( // R8
        ce_i && loaded && scen_now == 3'h4 && r_r.cfg[4:3] == 2'h2 &&
        cmd_addr_i == 16'he000 |=> prot_hit_o)
        else $error("upper window start not protected");

    chk_hi_size_miss: assert property ( // R8
        ce_i && loaded && scen_now == 3'h4 && r_r.cfg[4:3] == 2'h2 &&
        cmd_addr_i == 16'hdfff |=> !prot_hit_o)
        else $error("address below upper window protected");

    chk_lo_size_hit: assert property ( // R9
        ce_i && loaded && scen_now == 3'h6 && r_r.cfg[1:0] == 2'h1 &&
        cmd_addr_i == 16'h47ff |=> prot_hit_o)
        else $error("lower window end not protected");

    chk_lo_size_miss: assert property ( // R9
        ce_i && loaded && scen_now == 3'h6 && r_r.cfg[1:0] == 2'h1 &&
        cmd_addr_i == 16'h4800 |=> !prot_hit_o)
        else $error("address above lower window protected");

    chk_upper_off: assert property ( // R1
        ce_i && loaded && scen_now == 3'h6 && cmd_addr_i == 16'hffff
        |=> !prot_hit_o)
        else $error("disabled upper window still protected");

    chk_open_window: assert property ( // R7
        ce_i && loaded && scen_now == 3'h0 && r_r.cfg[4:3] == 2'h0 &&
        cmd_addr_i == 16'hf800 |=> !prot_hit_o)
        else $error("open upper window protected");

    chk_open_rest: assert property ( // R7
        ce_i && loaded && scen_now == 3'h0 && r_r.cfg[1:0] == 2'h0 &&
        cmd_addr_i == 16'h4400 |=> prot_hit_o)
        else $error("address outside open window unprotected");

    chk_lower_off: assert property ( // R3
        ce_i && loaded && scen_now == 3'h1 && cmd_addr_i == 16'h4000
        |=> prot_hit_o)
        else $error("disabled lower window left open");

    chk_full_sticks: assert property ( // R13
        loaded && scen_now == 3'h3 |=> scen_now == 3'h3)
        else $error("full protection was relaxed");

    chk_cfg_readback: assert property ( // R12
        ce_i && setup && paddr_i == frp_pkg::CFG_OFS
        |=> prdata_o == {24'h0, $past(r_r.cfg)})
        else $error("protection register read back wrong");

    chk_hold_unloaded: assert property ( // R10
        !loaded && !(ce_i && flash_rd_valid_i) |=> $stable(r_r.cfg))
        else $error("setting changed before it was loaded");

    chk_load_req: assert property ( // R16
        flash_rd_req_o == !loaded)
        else $error("load request disagrees with load state");

    cov_load: cover property (!loaded ##1 loaded);
    cov_cfg_write: cover property (loaded && wr && wmap == 3'h4
                                   ##1 $changed(r_r.cfg));
    cov_refused: cover property (loaded && wr && wmap == 3'h4
                                 ##1 $stable(r_r.cfg));
    cov_viol_irq: cover property (viol_ev ##[1:3] irq_o);
endmodule : frp_flash_range_protection
`default_nettype wire

// ==== hw/frp_pkg.sv ====
`default_nettype none
package frp_pkg;
    // ==================================================================
    // Register map (byte addresses on the APB slave)
    localparam logic [7:0] CFG_OFS         = 8'h00;
    localparam logic [7:0] STAT_OFS        = 8'h04;
    localparam logic [7:0] MASK_OFS        = 8'h08;
    localparam logic [7:0] STATE_OFS       = 8'h0c;
    // ==================================================================
    // Field positions of protection_config
    localparam int         POL_BIT         = 7;
    localparam int         SPARE_BIT       = 6;
    localparam int         UDIS_BIT        = 5;
    localparam int         LDIS_BIT        = 2;
    localparam logic [7:0] CFG_RST         = 8'hff;
    localparam logic       MASK_RST        = 1'b0;
    // ==================================================================
    // Flash map constants
    localparam logic [15:0] PROT_BYTE_ADDR = 16'hff0d;
    localparam logic [15:0] LO_BASE        = 16'h4000;
    localparam logic [63:0] HI_START       = 64'hc000_e000_f000_f800;
    localparam logic [63:0] LO_END         = 64'h5fff_4fff_47ff_43ff;
    // Row per source scenario, one bit per allowed target scenario
    localparam logic [63:0] ALLOWED        = 64'hff5a_3c18_080c_0a0f;
    typedef enum logic {
        FRP_LOAD = 1'b0,
        FRP_RUN  = 1'b1
    } frp_state_type;
endpackage : frp_pkg
`default_nettype wire

// ==== verif/frp_testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ==================================================================
    // Stimulus and observed signals
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        ce_i = 1'b1;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic        flash_rd_req_o;
    logic [15:0] flash_rd_addr_o;
    logic        flash_rd_valid_i = 1'b0;
    logic [7:0]  flash_rd_data_i = 8'h00;
    logic        cmd_valid_i = 1'b0;
    logic        cmd_pgm_ers_i = 1'b0;
    logic        cmd_mass_i = 1'b0;
    logic [15:0] cmd_addr_i = 16'h0;
    logic        prot_hit_o;
    logic        irq_o;
    int          num_errors = 0;
    int          tests_run = 0;
    logic [31:0] rv;
    logic        ev;

    frp_flash_range_protection dut (.clk_i(clk_i), .rst_i(rst_i),
        .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .flash_rd_req_o(flash_rd_req_o), .flash_rd_addr_o(flash_rd_addr_o),
        .flash_rd_valid_i(flash_rd_valid_i),
        .flash_rd_data_i(flash_rd_data_i), .cmd_valid_i(cmd_valid_i),
        .cmd_pgm_ers_i(cmd_pgm_ers_i), .cmd_mass_i(cmd_mass_i),
        .cmd_addr_i(cmd_addr_i), .prot_hit_o(prot_hit_o), .irq_o(irq_o));

    always #2.5 clk_i = ~clk_i;

    // ==================================================================
    // Shared tasks
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test

    task automatic chk(input string n, input logic [31:0] x,
                       input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask : chk

    // Request stands until the edge that samples pready high; data and
    // error are taken at that same edge, then the bus is released
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        logic ok;
        ok = 1'b0;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        for (int n = 0; n < 20 && !ok; n++) begin
            @(posedge clk_i);
            ok = (pready_o === 1'b1);
        end
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (!ok) begin
            chk("apb_timeout", 32'h1, 32'h0);
            stop_test();
        end
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rv, ev);
    endtask : wr

    task automatic rd(input string n, input logic [7:0] a,
                      input logic [31:0] x);
        apb(1'b0, a, 32'h0, rv, ev);
        chk(n, x, rv);
    endtask : rd

    task automatic hit(input logic [15:0] a, input logic x);
        @(posedge clk_i);
        cmd_addr_i <= a;
        @(posedge clk_i);
        @(negedge clk_i);
        chk("prot_hit", {31'h0, x}, {31'h0, prot_hit_o});
    endtask : hit

    task automatic cmd(input logic pe, input logic m, input logic [15:0] a);
        @(posedge clk_i);
        cmd_valid_i <= 1'b1;
        cmd_pgm_ers_i <= pe;
        cmd_mass_i <= m;
        cmd_addr_i <= a;
        @(posedge clk_i);
        cmd_valid_i <= 1'b0;
        @(negedge clk_i);
    endtask : cmd

    task automatic boot(input logic [7:0] b);
        rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk("load_req", 32'h1, {31'h0, flash_rd_req_o});
        chk("load_addr", 32'hff0d, {16'h0, flash_rd_addr_o});
        rd("cfg_reset", frp_pkg::CFG_OFS, 32'hff);
        cmd(1'b1, 1'b0, 16'h8000);
        rd("early_viol", frp_pkg::STAT_OFS, 32'h1);
        wr(frp_pkg::STAT_OFS, 32'h1);
        @(posedge clk_i);
        flash_rd_valid_i <= 1'b1;
        flash_rd_data_i <= b;
        @(posedge clk_i);
        flash_rd_valid_i <= 1'b0;
        rd("cfg_loaded", frp_pkg::CFG_OFS, {24'h0, b});
        chk("load_done", 32'h0, {31'h0, flash_rd_req_o});
    endtask : boot

    // ==================================================================
    // Scenarios
    task automatic test_pol1();
        rd("state", frp_pkg::STATE_OFS, 32'h0f);
        cmd(1'b0, 1'b1, 16'h0000);
        rd("mass_open", frp_pkg::STAT_OFS, 32'h0);
        wr(frp_pkg::CFG_OFS, 32'he9);
        rd("state6", frp_pkg::STATE_OFS, 32'h0e);
        hit(16'h47ff, 1'b1);
        hit(16'h4800, 1'b0);
        hit(16'hffff, 1'b0);
        wr(frp_pkg::CFG_OFS, 32'hed);
        rd("to7", frp_pkg::CFG_OFS, 32'he9);
        wr(frp_pkg::CFG_OFS, 32'he8);
        rd("lsize", frp_pkg::CFG_OFS, 32'he9);
        wr(frp_pkg::CFG_OFS, 32'hf1);
        rd("usize", frp_pkg::CFG_OFS, 32'hf1);
        wr(frp_pkg::CFG_OFS, 32'hd1);
        wr(frp_pkg::CFG_OFS, 32'hc9);
        rd("both", frp_pkg::CFG_OFS, 32'hd1);
        hit(16'hdfff, 1'b0);
        hit(16'he000, 1'b1);
        $display("test_pol1 done");
    endtask : test_pol1

    task automatic test_irq();
        wr(frp_pkg::MASK_OFS, 32'h1);
        cmd(1'b1, 1'b0, 16'h4000);
        chk("irq_on", 32'h1, {31'h0, irq_o});
        wr(frp_pkg::STAT_OFS, 32'h1);
        rd("clr", frp_pkg::STAT_OFS, 32'h0);
        chk("irq_off", 32'h0, {31'h0, irq_o});
        wr(frp_pkg::MASK_OFS, 32'h0);
        cmd(1'b0, 1'b1, 16'h0000);
        chk("irq_mask", 32'h0, {31'h0, irq_o});
        rd("mass_viol", frp_pkg::STAT_OFS, 32'h1);
        wr(frp_pkg::STAT_OFS, 32'h1);
        apb(1'b0, 8'h10, 32'h0, rv, ev);
        chk("unmapped", 32'h1, {31'h0, ev});
        $display("test_irq done");
    endtask : test_irq

    task automatic test_pol0();
        wr(frp_pkg::CFG_OFS, 32'h51);
        rd("to0", frp_pkg::CFG_OFS, 32'hd1);
        wr(frp_pkg::CFG_OFS, 32'h75);
        rd("to3", frp_pkg::CFG_OFS, 32'h75);
        hit(16'h0000, 1'b1);
        hit(16'h8000, 1'b1);
        wr(frp_pkg::CFG_OFS, 32'hf5);
        rd("pol_up", frp_pkg::CFG_OFS, 32'h75);
        $display("test_pol0 done");
    endtask : test_pol0

    task automatic test_open();
        boot(8'h40);
        hit(16'hf800, 1'b0);
        hit(16'hf7ff, 1'b1);
        hit(16'h43ff, 1'b0);
        hit(16'h4400, 1'b1);
        wr(frp_pkg::CFG_OFS, 32'h44);
        rd("to1", frp_pkg::CFG_OFS, 32'h44);
        hit(16'h4000, 1'b1);
        $display("test_open done");
    endtask : test_open

    // Clock enable low must freeze the flag and the decision alike
    task automatic test_ce();
        @(posedge clk_i);
        ce_i <= 1'b0;
        cmd(1'b1, 1'b0, 16'h0000);
        hit(16'hffff, 1'b1);
        @(posedge clk_i);
        ce_i <= 1'b1;
        rd("ce_viol", frp_pkg::STAT_OFS, 32'h0);
        hit(16'hffff, 1'b0);
        $display("test_ce done");
    endtask : test_ce

    initial begin
        boot(8'hff);
        test_pol1();
        test_irq();
        test_pol0();
        test_open();
        test_ce();
        stop_test();
    end
endmodule : testbench
`default_nettype wire
